// ---- hw/charge_cycle_sequencer.sv ----
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer
   import charge_seq_pkg::*;
#(
   parameter int unsigned SUB_CYCLES = charge_seq_pkg::SUB_CYCLES_DEF,
   parameter int unsigned PRECON_TICKS = charge_seq_pkg::PRECON_TICKS_DEF,
   parameter int unsigned FAST_TICKS = charge_seq_pkg::FAST_TICKS_DEF,
   parameter int unsigned TERM_TICKS = charge_seq_pkg::TERM_TICKS_DEF
)
(
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and comparator levels
   input wire logic en_pin,
   input wire logic vset_pin,
   input wire logic supply_ok,
   input wire logic temp_in_window,
   input wire logic temp_sense_disabled,
   input wire logic batt_above_precon,
   input wire logic batt_at_vreg,
   input wire logic batt_below_recharge,
   input wire logic current_below_term,
   input wire logic thermal_reg_active,
   input wire logic [7:0] current_ratio,
   // Open-drain indicators
   input wire logic charge_indicator_i,
   output logic charge_indicator_o,
   output logic charge_indicator_oe,
   input wire logic fault_indicator_i,
   output logic fault_indicator_o,
   output logic fault_indicator_oe,
   // Regulation loop controls
   output logic vreg_high,
   output logic precharge_on,
   output logic fast_charge_on,
   output logic cv_charge_on
);
   import charge_seq_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Input synchronisers
   localparam int NSYNC = 12;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [RATIO_W-1:0] ratio1_q;
   logic [RATIO_W-1:0] ratio2_q;

   assign raw_in = {fault_indicator_i, charge_indicator_i, thermal_reg_active, current_below_term,
                    batt_below_recharge, batt_at_vreg, batt_above_precon, temp_sense_disabled,
                    temp_in_window, supply_ok, vset_pin, en_pin};

   // Two flops per pin; first stage feeds only the second
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         ratio1_q <= '0;
         ratio2_q <= '0;
      end
      else
      begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         ratio1_q <= current_ratio;
         ratio2_q <= ratio1_q;
      end
   end

   // Named views of synchronised levels
   logic en_s, vset_s, supply_s, twin_s, tdis_s, above_pre_s;
   logic at_vreg_s, below_rch_s, below_term_s, thermreg_s;
   assign en_s = sync2_q[0];
   assign vset_s = sync2_q[1];
   assign supply_s = sync2_q[2];
   assign twin_s = sync2_q[3];
   assign tdis_s = sync2_q[4];
   assign above_pre_s = sync2_q[5];
   assign at_vreg_s = sync2_q[6];
   assign below_rch_s = sync2_q[7];
   assign below_term_s = sync2_q[8];
   assign thermreg_s = sync2_q[9];

   ////////////////////////////////////////////////////////////////
   // Register file
   logic [1:0] ctrl_q; // Software enable, complete-flash variant
   logic [7:0] scale_q; // Timing capacitor ratio, 16 = 0.1 uF
   logic [TIMER_W-1:0] elapsed_q;
   seq_state_t state_q;
   seq_state_t state_d;
   seq_state_t resume_q; // State to return to after a bad temperature
   logic chg_on_q; // Indicator sink requests
   logic flt_on_q;

   logic apb_access;
   logic apb_mapped;
   logic [31:0] rd_word;
   assign apb_access = psel && penable && pready;

   // Read mux and address decode
   always_comb
   begin
      rd_word = '0;
      apb_mapped = 1'b1;
      unique case (paddr)
         CTRL_OFF: rd_word[1:0] = ctrl_q;
         SCALE_OFF: rd_word[7:0] = scale_q;
         STATUS_OFF:
         begin
            rd_word[ST_STATE_LSB +: 4] = state_q;
            rd_word[ST_CHG_BIT] = chg_on_q;
            rd_word[ST_FLT_BIT] = flt_on_q;
            rd_word[ST_VREG_BIT] = vreg_high;
            rd_word[ST_CHG_PIN_BIT] = sync2_q[10];
            rd_word[ST_FLT_PIN_BIT] = sync2_q[11];
            rd_word[ST_RESUME_LSB +: 4] = resume_q;
         end
         ELAPSED_OFF: rd_word[TIMER_W-1:0] = elapsed_q;
         default: apb_mapped = 1'b0;
      endcase
   end

   // No wait state: ready rises in the first access cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !pready;
         prdata <= rd_word;
         pslverr <= psel && !pready && !apb_mapped; // Error stands with ready, one cycle only
      end
   end

   // Writable registers; a zero scale is held at one to keep the clock alive
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= CTRL_RST;
         scale_q <= SCALE_RST;
      end
      else if (apb_access && pwrite)
      begin
         if (paddr == CTRL_OFF)
         begin
            ctrl_q <= pwdata[1:0];
         end
         if (paddr == SCALE_OFF)
         begin
            scale_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Timing-capacitor clock: a tick every scale/16 half-seconds
   logic [31:0] sub_cnt_q;
   logic [7:0] sub_idx_q;
   logic tick;
   logic sub_wrap;
   assign sub_wrap = (sub_cnt_q == SUB_CYCLES - 1);
   assign tick = sub_wrap && (sub_idx_q >= scale_q - 8'h01);

   // Prescaler, period scales with capacitance
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sub_cnt_q <= '0;
         sub_idx_q <= '0;
      end
      else if (sub_wrap)
      begin
         sub_cnt_q <= '0;
         sub_idx_q <= tick ? 8'h00 : sub_idx_q + 8'h01;
      end
      else
      begin
         sub_cnt_q <= sub_cnt_q + 32'h1;
      end
   end

   // Flash phase toggles each tick: 1 Hz, 50% at unity scale
   logic flash_q;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         flash_q <= 1'b0;
      end
      else if (tick)
      begin
         flash_q <= !flash_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Timer advance, slowed under thermal regulation
   logic [RATIO_W:0] slow_acc_q;
   logic [RATIO_W:0] slow_sum;
   logic advance;
   assign slow_sum = {1'b0, slow_acc_q[RATIO_W-1:0]} + {1'b0, ratio2_q};
   assign advance = tick && (!thermreg_s || slow_sum[RATIO_W]);

   // Fractional accumulator; ratio/256 of ticks advance the timers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         slow_acc_q <= '0;
      end
      else if (tick && thermreg_s)
      begin
         slow_acc_q <= slow_sum;
      end
   end

   logic [TIMER_W-1:0] precon_q;
   logic [TIMER_W-1:0] fast_q;
   logic precon_exp, fast_exp, term_exp;
   assign precon_exp = (precon_q >= TIMER_W'(PRECON_TICKS));
   assign fast_exp = (fast_q >= TIMER_W'(FAST_TICKS));
   assign term_exp = (elapsed_q >= TIMER_W'(TERM_TICKS));

   // Preconditioning timer
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         precon_q <= '0;
      end
      else if (state_q != ST_PRECON && state_q != ST_TEMP_BAD)
      begin
         precon_q <= '0;
      end
      else if (state_q == ST_PRECON && advance && !precon_exp)
      begin
         precon_q <= precon_q + 1'b1;
      end
   end

   // Fast-charge timer; held while temperature suspends the cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         fast_q <= '0;
      end
      else if (state_q != ST_FAST && state_q != ST_TEMP_BAD)
      begin
         fast_q <= '0;
      end
      else if (state_q == ST_FAST && advance && !fast_exp)
      begin
         fast_q <= fast_q + 1'b1;
      end
   end

   // Elapsed timer spans fast charge and constant voltage
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         elapsed_q <= '0;
      end
      else if (state_q == ST_QUAL)
      begin
         elapsed_q <= '0;
      end
      else if ((state_q == ST_FAST || state_q == ST_CV) && advance && !term_exp)
      begin
         elapsed_q <= elapsed_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sequencer
   logic enabled;
   logic temp_ok;
   assign enabled = en_s && ctrl_q[CTRL_EN_BIT];
   assign temp_ok = twin_s || tdis_s;

   // Next state; supply and enable override everything
   always_comb
   begin
      state_d = state_q;
      if (!supply_s)
      begin
         state_d = ST_NO_SUPPLY;
      end
      else if (!enabled)
      begin
         state_d = ST_SLEEP;
      end
      else
      begin
         unique case (state_q)
            ST_NO_SUPPLY, ST_SLEEP: state_d = ST_QUAL;
            ST_QUAL:
            begin
               if (!temp_ok)
               begin
                  state_d = ST_TEMP_BAD;
               end
               else
               begin
                  state_d = above_pre_s ? ST_FAST : ST_PRECON;
               end
            end
            ST_PRECON:
            begin
               if (!temp_ok)
               begin
                  state_d = ST_TEMP_BAD;
               end
               else if (above_pre_s)
               begin
                  state_d = ST_FAST;
               end
               else if (precon_exp)
               begin
                  state_d = ST_FAULT;
               end
            end
            ST_FAST:
            begin
               if (!temp_ok)
               begin
                  state_d = ST_TEMP_BAD;
               end
               else if (at_vreg_s)
               begin
                  state_d = ST_CV;
               end
               else if (fast_exp)
               begin
                  state_d = ST_FAULT;
               end
            end
            ST_CV:
            begin
               if (!temp_ok)
               begin
                  state_d = ST_TEMP_BAD;
               end
               else if (below_term_s || term_exp)
               begin
                  state_d = ST_DONE;
               end
            end
            ST_DONE:
            begin
               if (below_rch_s)
               begin
                  state_d = ST_QUAL;
               end
            end
            ST_FAULT: state_d = ST_FAULT;
            ST_TEMP_BAD:
            begin
               if (temp_ok)
               begin
                  state_d = resume_q;
               end
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_NO_SUPPLY;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Remember where a temperature suspension interrupted the cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         resume_q <= ST_QUAL;
      end
      else if (state_d == ST_TEMP_BAD && state_q != ST_TEMP_BAD)
      begin
         resume_q <= state_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Indicator modes from next state
   ind_mode_t chg_mode;
   ind_mode_t flt_mode;
   always_comb
   begin
      chg_mode = IND_OFF;
      flt_mode = IND_OFF;
      unique case (state_d)
         ST_PRECON, ST_FAST, ST_CV: chg_mode = IND_ON;
         ST_DONE: chg_mode = ctrl_q[CTRL_FLASH_BIT] ? IND_FLASH : IND_OFF;
         ST_FAULT: flt_mode = IND_ON;
         ST_TEMP_BAD: flt_mode = IND_FLASH;
         default: chg_mode = IND_OFF;
      endcase
   end

   // Sink requests; flashing alternates off and on
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         chg_on_q <= 1'b0;
         flt_on_q <= 1'b0;
      end
      else
      begin
         chg_on_q <= (chg_mode == IND_ON) || (chg_mode == IND_FLASH && flash_q);
         flt_on_q <= (flt_mode == IND_ON) || (flt_mode == IND_FLASH && flash_q);
      end
   end
   assign charge_indicator_oe = chg_on_q;
   assign fault_indicator_oe = flt_on_q;
   assign charge_indicator_o = 1'b0; // Open drain only pulls low
   assign fault_indicator_o = 1'b0;

   ////////////////////////////////////////////////////////////////
   // Regulation loop controls
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         vreg_high <= 1'b0;
         precharge_on <= 1'b0;
         fast_charge_on <= 1'b0;
         cv_charge_on <= 1'b0;
      end
      else
      begin
         vreg_high <= vset_s;
         precharge_on <= (state_d == ST_PRECON);
         fast_charge_on <= (state_d == ST_FAST);
         cv_charge_on <= (state_d == ST_CV);
      end
   end
endmodule
`default_nettype wire

// ---- hw/charge_seq_pkg.sv ----
package charge_seq_pkg;
   // Clock and time base
   localparam longint CLK_PERIOD_PS = 4000;
   localparam longint FLASH_HALF_MS = 500;
   localparam longint SCALE_UNITY = 16;
   localparam longint SUB_CYCLES_L = (FLASH_HALF_MS * 64'd1000000000) / CLK_PERIOD_PS / SCALE_UNITY;
   localparam int unsigned SUB_CYCLES_DEF = int'(SUB_CYCLES_L);
   // Safety timer periods in tenths of an hour at unity scale
   localparam int unsigned PRECON_HOURS_X10 = 10;
   localparam int unsigned FAST_HOURS_X10 = 15;
   localparam int unsigned TERM_HOURS_X10 = 30;
   localparam int unsigned TICKS_PER_HOUR = 7200;
   localparam int unsigned PRECON_TICKS_DEF = PRECON_HOURS_X10 * TICKS_PER_HOUR / 10;
   localparam int unsigned FAST_TICKS_DEF = FAST_HOURS_X10 * TICKS_PER_HOUR / 10;
   localparam int unsigned TERM_TICKS_DEF = TERM_HOURS_X10 * TICKS_PER_HOUR / 10;
   localparam int TIMER_W = 16;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] SCALE_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] ELAPSED_OFF = 8'h0C;
   // Control fields and reset values
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FLASH_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam logic [7:0] SCALE_RST = 8'h10;
   // Status fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CHG_BIT = 4;
   localparam int ST_FLT_BIT = 5;
   localparam int ST_VREG_BIT = 6;
   localparam int ST_CHG_PIN_BIT = 7;
   localparam int ST_FLT_PIN_BIT = 8;
   localparam int ST_RESUME_LSB = 12;
   // Current ratio scale, full programmed current
   localparam int RATIO_W = 8;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_NO_SUPPLY,
      ST_SLEEP,
      ST_QUAL,
      ST_PRECON,
      ST_FAST,
      ST_CV,
      ST_DONE,
      ST_FAULT,
      ST_TEMP_BAD
   } seq_state_t;
   // Indicator drive
   typedef enum logic [1:0] {
      IND_OFF,
      IND_ON,
      IND_FLASH
   } ind_mode_t;
endpackage

// ---- verification/charge_seq_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the charge sequencer
module charge_seq_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic en_pin,
   input wire logic vset_pin,
   input wire logic supply_ok,
   input wire logic charge_indicator_o,
   input wire logic charge_indicator_oe,
   input wire logic fault_indicator_o,
   input wire logic fault_indicator_oe,
   input wire logic vreg_high,
   input wire logic precharge_on,
   input wire logic fast_charge_on,
   input wire logic cv_charge_on
);
   // One domain; reset aborts every attempt
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Open drain never drives a high level
   chk_od_never_high: assert property (!charge_indicator_o && !fault_indicator_o)
      else $error("indicator data driven high");
   // No table row has both indicators sinking
   chk_ind_exclusive: assert property (charge_indicator_oe |-> !fault_indicator_oe)
      else $error("both indicators on");
   // Charging modes light the charge indicator only
   chk_charge_ind_on: assert property ((precharge_on || fast_charge_on || cv_charge_on)
      |-> charge_indicator_oe && !fault_indicator_oe)
      else $error("charge indicator wrong while charging");
   // One regulation mode at a time
   chk_mode_onehot: assert property ($onehot0({precharge_on, fast_charge_on, cv_charge_on}))
      else $error("several charge modes at once");
   // Sync plus register fits in six cycles
   chk_vset_high: assert property (vset_pin [*6] |-> vreg_high)
      else $error("high target not selected");
   chk_vset_low: assert property (!vset_pin [*6] |-> !vreg_high)
      else $error("low target not selected");
   // Lost supply darkens both indicators
   chk_supply_dark: assert property (!supply_ok [*6] |-> !charge_indicator_oe && !fault_indicator_oe)
      else $error("indicator on without supply");
   // Disabled device sleeps with indicators off
   chk_sleep_dark: assert property (!en_pin [*6] |-> !charge_indicator_oe && !fault_indicator_oe)
      else $error("indicator on while disabled");
   // Bus answer one cycle after setup, for one cycle
   chk_ready_wait: assert property (psel && !penable |=> pready)
      else $error("ready not one cycle after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held over one cycle");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule
bind charge_cycle_sequencer charge_seq_checker chk_u (.ref_clk, .rst, .psel, .penable, .pready,
   .pslverr, .en_pin, .vset_pin, .supply_ok, .charge_indicator_o, .charge_indicator_oe,
   .fault_indicator_o, .fault_indicator_oe, .vreg_high, .precharge_on, .fast_charge_on, .cv_charge_on);
`default_nettype wire

// ---- verification/status_pullup_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the status pins: pull-ups resolve the open drains
module status_pullup_model (
   input wire logic chg_o,
   input wire logic chg_oe,
   input wire logic flt_o,
   input wire logic flt_oe,
   output logic chg_lvl,
   output logic flt_lvl
);
   // Released pin floats up, driven pin sinks
   assign chg_lvl = chg_oe ? chg_o : 1'b1;
   assign flt_lvl = flt_oe ? flt_o : 1'b1;
endmodule
`default_nettype wire

// ---- verification/test_charge_cycle_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_charge_cycle_sequencer;
   import charge_seq_pkg::*;
   // Cycles per timer tick: SUB_CYCLES 2 times unity scale 16
   localparam int TK = 32;
   logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, current_ratio = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, chg_o, chg_oe, flt_o, flt_oe, chg_lvl, flt_lvl;
   logic vreg_high, pre_on, fast_on, cv_on;
   logic en_pin = 1, vset_pin = 0, supply_ok = 0, temp_in_window = 1, temp_sense_disabled = 0;
   logic batt_above_precon = 0, batt_at_vreg = 0, batt_below_recharge = 0;
   logic current_below_term = 0, thermal_reg_active = 0;
   int mismatches = 0, num_checks = 0;
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   // Short counts keep the run brief
   charge_cycle_sequencer #(.SUB_CYCLES(2), .PRECON_TICKS(4), .FAST_TICKS(6), .TERM_TICKS(12)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .en_pin(en_pin),
      .vset_pin(vset_pin), .supply_ok(supply_ok), .temp_in_window(temp_in_window),
      .temp_sense_disabled(temp_sense_disabled), .batt_above_precon(batt_above_precon),
      .batt_at_vreg(batt_at_vreg), .batt_below_recharge(batt_below_recharge),
      .current_below_term(current_below_term), .thermal_reg_active(thermal_reg_active),
      .current_ratio(current_ratio), .charge_indicator_i(chg_lvl), .charge_indicator_o(chg_o),
      .charge_indicator_oe(chg_oe), .fault_indicator_i(flt_lvl), .fault_indicator_o(flt_o),
      .fault_indicator_oe(flt_oe), .vreg_high(vreg_high), .precharge_on(pre_on),
      .fast_charge_on(fast_on), .cv_charge_on(cv_on));
   status_pullup_model host_u (.chg_o(chg_o), .chg_oe(chg_oe), .flt_o(flt_o), .flt_oe(flt_oe),
      .chg_lvl(chg_lvl), .flt_lvl(flt_lvl));
   ////////////////////////////////////////
   task automatic go(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // APB transfer; ready, read data and error all taken at one rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         $display("wrong value pready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Sequencer state through the status word
   task automatic st(logic [3:0] e);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("state", 32'(e), 32'(rd[3:0]));
   endtask
   // Pin levels as the pull-ups show them
   task automatic pins(logic c, logic f);
      @(posedge ref_clk);
      chk("charge pin", 32'(c), 32'(chg_lvl));
      chk("fault pin", 32'(f), 32'(flt_lvl));
   endtask
   function automatic logic lv(bit f);
      return f ? flt_lvl : chg_lvl;
   endfunction
   // First loop finds a toggle, second times a whole half period
   task automatic flash(bit f);
      int n;
      logic v;
      for (int k = 0; k < 2; k++)
      begin
         v = lv(f);
         n = 0;
         while (lv(f) === v && n < 4 * TK)
         begin
            @(posedge ref_clk);
            n++;
         end
      end
      chk("flash half period", TK, n);
   endtask
   ////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, CTRL_OFF, 32'h0);
      chk("ctrl", 32'h3, rd);
      apb(1'b0, SCALE_OFF, 32'h0);
      chk("scale", 32'h10, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, STATUS_OFF, 32'h0000_0005);
      st(ST_NO_SUPPLY);
      pins(1, 1);
      $display("test regs done");
   endtask
   // Throttled precondition timeout, then fault recovery
   task automatic t_precon();
      supply_ok <= 1;
      go(12);
      st(ST_PRECON);
      pins(0, 1);
      thermal_reg_active <= 1;
      current_ratio <= 8'h80;
      go(5 * TK);
      st(ST_PRECON);
      go(5 * TK);
      st(ST_FAULT);
      pins(1, 0);
      thermal_reg_active <= 0;
      batt_above_precon <= 1;
      go(12);
      st(ST_FAULT);
      en_pin <= 0;
      go(12);
      st(ST_SLEEP);
      pins(1, 1);
      en_pin <= 1;
      go(12);
      st(ST_FAST);
      $display("test precon done");
   endtask
   // CV outlives the fast limit; elapsed expiry completes
   task automatic t_cycle();
      batt_at_vreg <= 1;
      go(12);
      st(ST_CV);
      pins(0, 1);
      go(8 * TK);
      st(ST_CV);
      go(5 * TK);
      st(ST_DONE);
      flash(0);
      pins(lv(0), 1);
      apb(1'b1, CTRL_OFF, 32'h1);
      go(8);
      pins(1, 1);
      apb(1'b1, CTRL_OFF, 32'h3);
      batt_at_vreg <= 0;
      batt_below_recharge <= 1;
      go(12);
      st(ST_FAST);
      batt_below_recharge <= 0;
      // Current falling below termination also completes the cycle
      current_below_term <= 1;
      batt_at_vreg <= 1;
      go(12);
      st(ST_DONE);
      current_below_term <= 0;
      batt_at_vreg <= 0;
      batt_below_recharge <= 1;
      go(12);
      st(ST_FAST);
      batt_below_recharge <= 0;
      $display("test cycle done");
   endtask
   task automatic t_fast();
      go(4 * TK);
      st(ST_FAST);
      go(3 * TK);
      st(ST_FAULT);
      en_pin <= 0;
      go(12);
      en_pin <= 1;
      go(12);
      st(ST_FAST);
      $display("test fast done");
   endtask
   task automatic t_temp();
      temp_in_window <= 0;
      go(12);
      st(ST_TEMP_BAD);
      flash(1);
      pins(1, lv(1));
      temp_sense_disabled <= 1;
      go(12);
      st(ST_FAST);
      temp_sense_disabled <= 0;
      go(12);
      st(ST_TEMP_BAD);
      temp_in_window <= 1;
      go(12);
      st(ST_FAST);
      vset_pin <= 1;
      go(8);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("vreg status", 32'h1, 32'(rd[ST_VREG_BIT]));
      supply_ok <= 0;
      go(12);
      st(ST_NO_SUPPLY);
      pins(1, 1);
      $display("test temp done");
   endtask
   ////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence after six reset cycles
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst <= 0;
      t_regs();
      t_precon();
      t_cycle();
      t_fast();
      t_temp();
      test_done();
   end
   // Watchdog well past the expected run length
   initial
   begin
      #80000;
      mismatches++;
      test_done();
   end
endmodule
`default_nettype wire
